// File: logic/iop_pkg.sv
package iop_pkg;

    // Byte addresses of the register words on the APB bus.
    localparam logic [7:0] IOP_WAKE_DATA_OFS = 8'h00;
    localparam logic [7:0] IOP_WAKE_CFG_OFS  = 8'h04;
    localparam logic [7:0] IOP_WAKE_PIN_OFS  = 8'h08;
    localparam logic [7:0] IOP_GEN_DATA_OFS  = 8'h0c;
    localparam logic [7:0] IOP_GEN_CFG_OFS   = 8'h10;
    localparam logic [7:0] IOP_GEN_PIN_OFS   = 8'h14;
    localparam logic [7:0] IOP_ANA_PIN_OFS   = 8'h18;
    localparam logic [7:0] IOP_OUT_DATA_OFS  = 8'h1c;
    localparam logic [7:0] IOP_CTRL_OFS      = 8'h20;
    localparam logic [7:0] IOP_STATUS_OFS    = 8'h24;
    localparam logic [7:0] IOP_MASK_OFS      = 8'h28;

    // Values after reset, and the fixed read value of the low wake pin bits.
    localparam logic [7:0] IOP_PORT_RST      = 8'h00;
    localparam logic [3:0] IOP_OUT_RST       = 4'hf;
    localparam logic [3:0] IOP_WAKE_LOW_READ = 4'hf;
    localparam logic [5:0] IOP_STATUS_RST    = 6'h00;

    // Field positions in the general port and control words.
    localparam int IOP_GEN_STOP_BIT  = 7;
    localparam int IOP_GEN_IDLE_BIT  = 6;
    localparam int IOP_GEN_FAULT_BIT = 1;
    localparam int IOP_GEN_SCK_BIT   = 5;
    localparam int IOP_GEN_SDO_BIT   = 4;
    localparam int IOP_CTRL_SEL_BIT  = 0;

    // Status layout: wake pin rises in 3:0, external irq, stop exit.
    localparam int IOP_ST_W          = 6;
    localparam int IOP_ST_EXTIRQ_BIT = 4;
    localparam int IOP_ST_RESTART_BIT = 5;

    // Bus answer phase of the slave.
    typedef enum logic [0:0] {
        IOP_BUS_WAIT = 1'b0,
        IOP_BUS_DONE = 1'b1
    } iop_bus_t;

endpackage

// File: logic/iop_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module iop_pin_cell (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic cfg,
    input  wire logic dat,
    output var  logic pin_out,
    output var  logic pin_oe_n,
    output var  logic pin_pu
);

    // Registered decode of one configuration and data bit pair.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
            pin_pu   <= 1'b0;
        end else begin
            pin_out  <= cfg & dat; // RL1
            pin_oe_n <= ~cfg; // RL1
            pin_pu   <= ~cfg & dat; // RL1
        end
    end

    property p_decode;
        @(posedge pclk) disable iff (!presetn)
        presetn |=> (pin_oe_n == !$past(cfg))
              && (pin_pu == (!$past(cfg) && $past(dat)))
              && (pin_out == ($past(cfg) && $past(dat)));
    endproperty
    a_decode: assert property (p_decode) // RL1
        else $error("pin cell decode wrong");

endmodule

`default_nettype wire

// File: logic/iop_port_set.sv
// Contract
// RL1: Config and data bit pair gives hi-z, pull-up, drive low or drive high.
// RL2: Each two-way port has config, data and read-only pin words.
// RL3: Wake port pins offer wakeup detection or external interrupt use.
// RL4: Wake port lower four pin bits read ones; their flags stay usable.
// RL5: General port: bits 0,2-5 I/O, 6 input, 1 fault out, 7 oscillator.
// RL6: General port data bits 6 and 7 read back as zero.
// RL7: Writing one to general data bit 7 enters clock-stopping mode.
// RL8: Writing one to general data bit 6 enters idle mode.
// RL9: General config bit 6 selects the alternate serial clock phase.
// RL10: General config bit 7 with RC option enables restart delay.
// RL11: RC option: bit 7 is an input whose rise ends stopping mode.
// RL12: Crystal option: bit 7 drives the oscillator clock output only.
// RL13: General port pins carry serial, timer and interrupt alternates.
// RL14: Analog port is an eight-bit input-only port for analog block.
// RL15: Output-only port is all ones while reset is low.
// RL16: Reset clears wake and general data and config, pins hi-z.
// RL17: Select bit routes serial clock and data out onto bits 5, 4.
// RL18: Pin reads return clocked pin levels, not data register values.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module iop_port_set #(
    parameter int WAKE_W = 4,
    parameter int GEN_W  = 8,
    parameter int ANA_W  = 8,
    parameter int OUT_W  = 4
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic [WAKE_W-1:0]  wake_pin_in,
    output var  logic [WAKE_W-1:0]  wake_pin_out,
    output var  logic [WAKE_W-1:0]  wake_pin_oe_n,
    output var  logic [WAKE_W-1:0]  wake_pin_pu,
    input  wire logic [GEN_W-1:0]   gen_pin_in,
    output var  logic [GEN_W-1:0]   gen_pin_out,
    output var  logic [GEN_W-1:0]   gen_pin_oe_n,
    output var  logic [GEN_W-1:0]   gen_pin_pu,
    input  wire logic [ANA_W-1:0]   analog_pin_in,
    output var  logic [ANA_W-1:0]   analog_level,
    output var  logic [OUT_W-1:0]   out_port,
    input  wire logic               osc_rc_option,
    input  wire logic               osc_clock_in,
    input  wire logic               fault_monitor_in,
    input  wire logic               serial_clock_src,
    input  wire logic               serial_data_src,
    output var  logic               serial_data_in,
    output var  logic               serial_alt_phase,
    output var  logic               timer_io_pin,
    output var  logic               timer_capture_pin,
    output var  logic               ext_irq_in,
    output var  logic [WAKE_W-1:0]  multi_input_wakeup,
    output var  logic               stop_mode,
    output var  logic               idle_req,
    output var  logic               restart_delay_en,
    output var  logic               irq
);
    import iop_pkg::*;

    logic [7:0]          wake_data_reg;
    logic [7:0]          wake_cfg_reg;
    logic [5:0]          gen_data_reg;
    logic [7:0]          gen_cfg_reg;
    logic [OUT_W-1:0]    out_reg;
    logic                ctrl_sel_reg;
    logic [IOP_ST_W-1:0] status_reg;
    logic [IOP_ST_W-1:0] status_next;
    logic [IOP_ST_W-1:0] mask_reg;
    logic [WAKE_W-1:0]   wake_s_reg;
    logic [WAKE_W-1:0]   wake_d_reg;
    logic [GEN_W-1:0]    gen_s_reg;
    logic [GEN_W-1:0]    gen_d_reg;
    logic [ANA_W-1:0]    ana_s_reg;
    iop_bus_t            bus_reg;
    logic [31:0]         rd_data;
    logic                rd_ok;
    logic                acc;
    logic                wr_en;
    logic                rd_done;
    logic [WAKE_W-1:0]   wake_rise;
    logic                extirq_rise;
    logic                restart_rise;
    logic [GEN_W-1:0]    gen_cfg_eff;
    logic [GEN_W-1:0]    gen_dat_eff;

    // Access phase, completing write and completing read.
    assign acc     = psel & penable;
    assign wr_en   = acc & (bus_reg == IOP_BUS_DONE) & pwrite;
    assign rd_done = acc & (bus_reg == IOP_BUS_DONE) & ~pwrite;

    // Pins are sampled once on the clock and kept one more for edges.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_s_reg <= '0;
            wake_d_reg <= '0;
            gen_s_reg  <= '0;
            gen_d_reg  <= '0;
            ana_s_reg  <= '0;
        end else begin
            wake_s_reg <= wake_pin_in; // RL18
            wake_d_reg <= wake_s_reg;
            gen_s_reg  <= gen_pin_in; // RL18
            gen_d_reg  <= gen_s_reg;
            ana_s_reg  <= analog_pin_in; // RL14
        end
    end

    // Rising edges that become wake, interrupt and restart events.
    assign wake_rise    = wake_s_reg & ~wake_d_reg; // RL3
    assign extirq_rise  = gen_s_reg[0] & ~gen_d_reg[0]; // RL13
    assign restart_rise = osc_rc_option & gen_s_reg[IOP_GEN_STOP_BIT]
                        & ~gen_d_reg[IOP_GEN_STOP_BIT]; // RL11

    // Wake port registers; the low nibble serves as software flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_data_reg <= IOP_PORT_RST; // RL16
            wake_cfg_reg  <= IOP_PORT_RST; // RL16
        end else if (wr_en && paddr == IOP_WAKE_DATA_OFS) begin
            wake_data_reg <= pwdata[7:0]; // RL4
        end else if (wr_en && paddr == IOP_WAKE_CFG_OFS) begin
            wake_cfg_reg  <= pwdata[7:0]; // RL2
        end
    end

    // General port data for the I/O bits and its configuration word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_data_reg <= IOP_PORT_RST[5:0]; // RL16
            gen_cfg_reg  <= IOP_PORT_RST; // RL16
        end else if (wr_en && paddr == IOP_GEN_DATA_OFS) begin
            gen_data_reg <= pwdata[5:0]; // RL2
        end else if (wr_en && paddr == IOP_GEN_CFG_OFS) begin
            gen_cfg_reg  <= pwdata[7:0]; // RL2
        end
    end

    // Output-only port, forced high by reset, and the select bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg      <= IOP_OUT_RST; // RL15
            ctrl_sel_reg <= 1'b0;
        end else if (wr_en && paddr == IOP_OUT_DATA_OFS) begin
            out_reg      <= pwdata[OUT_W-1:0];
        end else if (wr_en && paddr == IOP_CTRL_OFS) begin
            ctrl_sel_reg <= pwdata[IOP_CTRL_SEL_BIT];
        end
    end

    // Stop mode holds until a restart edge; idle is a one-cycle request.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_mode <= 1'b0;
            idle_req  <= 1'b0;
        end else begin
            if (wr_en && paddr == IOP_GEN_DATA_OFS
                && pwdata[IOP_GEN_STOP_BIT]) begin
                stop_mode <= 1'b1; // RL7
            end else if (restart_rise) begin
                stop_mode <= 1'b0; // RL11
            end
            idle_req <= wr_en && paddr == IOP_GEN_DATA_OFS
                        && pwdata[IOP_GEN_IDLE_BIT]; // RL8
        end
    end

    // Sticky events; a read clears what it returned and a new event wins.
    always_comb begin
        status_next = status_reg;
        if (rd_done && paddr == IOP_STATUS_OFS) begin
            status_next = status_reg & ~prdata[IOP_ST_W-1:0];
        end
        status_next = status_next | {restart_rise, extirq_rise, wake_rise};
    end

    // Status, mask and the interrupt level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= IOP_STATUS_RST;
            mask_reg   <= IOP_STATUS_RST;
            irq        <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_en && paddr == IOP_MASK_OFS) begin
                mask_reg <= pwdata[IOP_ST_W-1:0];
            end
            irq <= |(status_reg & mask_reg);
        end
    end

    // Read word for the addressed register.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (paddr == IOP_WAKE_DATA_OFS) begin
            rd_data[7:0] = wake_data_reg;
        end else if (paddr == IOP_WAKE_CFG_OFS) begin
            rd_data[7:0] = wake_cfg_reg;
        end else if (paddr == IOP_WAKE_PIN_OFS) begin
            rd_data[7:0] = {wake_s_reg, IOP_WAKE_LOW_READ}; // RL4
        end else if (paddr == IOP_GEN_DATA_OFS) begin
            rd_data[7:0] = {2'b00, gen_data_reg}; // RL6
        end else if (paddr == IOP_GEN_CFG_OFS) begin
            rd_data[7:0] = gen_cfg_reg;
        end else if (paddr == IOP_GEN_PIN_OFS) begin
            rd_data[7:0] = gen_s_reg; // RL18
        end else if (paddr == IOP_ANA_PIN_OFS) begin
            rd_data[7:0] = ana_s_reg; // RL14
        end else if (paddr == IOP_OUT_DATA_OFS) begin
            rd_data[OUT_W-1:0] = out_reg;
        end else if (paddr == IOP_CTRL_OFS) begin
            rd_data[IOP_CTRL_SEL_BIT] = ctrl_sel_reg;
        end else if (paddr == IOP_STATUS_OFS) begin
            rd_data[IOP_ST_W-1:0] = status_reg;
        end else if (paddr == IOP_MASK_OFS) begin
            rd_data[IOP_ST_W-1:0] = mask_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // One wait cycle per access; data and error are loaded with ready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_reg <= IOP_BUS_WAIT;
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (acc && bus_reg == IOP_BUS_WAIT) begin
            bus_reg <= IOP_BUS_DONE;
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= ~rd_ok;
        end else begin
            bus_reg <= IOP_BUS_WAIT;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Effective pin controls of the general port per bit role.
    always_comb begin
        gen_cfg_eff = gen_cfg_reg; // RL5
        gen_dat_eff = {2'b00, gen_data_reg};
        gen_cfg_eff[IOP_GEN_FAULT_BIT] = fault_monitor_in; // RL5
        gen_dat_eff[IOP_GEN_FAULT_BIT] = 1'b0;
        gen_cfg_eff[IOP_GEN_IDLE_BIT]  = 1'b0; // RL5
        gen_dat_eff[IOP_GEN_IDLE_BIT]  = 1'b0;
        gen_cfg_eff[IOP_GEN_STOP_BIT]  = ~osc_rc_option; // RL12
        gen_dat_eff[IOP_GEN_STOP_BIT]  = ~osc_rc_option & osc_clock_in;
        if (ctrl_sel_reg) begin
            gen_dat_eff[IOP_GEN_SCK_BIT] = serial_clock_src; // RL17
            gen_dat_eff[IOP_GEN_SDO_BIT] = serial_data_src; // RL17
        end
    end

    // One pin cell per wake bit, driven from the upper nibble.
    for (genvar i = 0; i < WAKE_W; i++) begin : g_wake
        iop_pin_cell u_cell (
            .pclk     (pclk),
            .presetn  (presetn),
            .cfg      (wake_cfg_reg[i+4]),
            .dat      (wake_data_reg[i+4]),
            .pin_out  (wake_pin_out[i]),
            .pin_oe_n (wake_pin_oe_n[i]),
            .pin_pu   (wake_pin_pu[i])
        );
    end

    // One pin cell per general port bit.
    for (genvar i = 0; i < GEN_W; i++) begin : g_gen
        iop_pin_cell u_cell (
            .pclk     (pclk),
            .presetn  (presetn),
            .cfg      (gen_cfg_eff[i]),
            .dat      (gen_dat_eff[i]),
            .pin_out  (gen_pin_out[i]),
            .pin_oe_n (gen_pin_oe_n[i]),
            .pin_pu   (gen_pin_pu[i])
        );
    end

    // Registered alternate functions and mode levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_level       <= '0;
            out_port           <= IOP_OUT_RST; // RL15
            serial_data_in     <= 1'b0;
            serial_alt_phase   <= 1'b0;
            timer_io_pin       <= 1'b0;
            timer_capture_pin  <= 1'b0;
            ext_irq_in         <= 1'b0;
            multi_input_wakeup <= '0;
            restart_delay_en   <= 1'b0;
        end else begin
            analog_level       <= ana_s_reg; // RL14
            out_port           <= out_reg;
            serial_data_in     <= gen_s_reg[IOP_GEN_IDLE_BIT]; // RL13
            serial_alt_phase   <= gen_cfg_reg[IOP_GEN_IDLE_BIT]; // RL9
            timer_io_pin       <= gen_s_reg[3]; // RL13
            timer_capture_pin  <= gen_s_reg[2]; // RL13
            ext_irq_in         <= gen_s_reg[0]; // RL13
            multi_input_wakeup <= wake_rise; // RL3
            restart_delay_en   <= gen_cfg_reg[IOP_GEN_STOP_BIT]
                                  & osc_rc_option; // RL10
        end
    end

    property p_wake_low_ones;
        @(posedge pclk) disable iff (!presetn)
        (acc && pready && !pwrite && paddr == IOP_WAKE_PIN_OFS)
            |-> prdata[3:0] == 4'hf;
    endproperty
    a_wake_low_ones: assert property (p_wake_low_ones) // RL4
        else $error("wake pin low nibble not ones");

    property p_gen_hi_zero;
        @(posedge pclk) disable iff (!presetn)
        (acc && pready && !pwrite && paddr == IOP_GEN_DATA_OFS)
            |-> prdata[7:6] == 2'b00;
    endproperty
    a_gen_hi_zero: assert property (p_gen_hi_zero) // RL6
        else $error("general data bits 7:6 not zero");

    property p_stop_enter;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == IOP_GEN_DATA_OFS && pwdata[7])
            |=> stop_mode [*2];
    endproperty
    a_stop_enter: assert property (p_stop_enter) // RL7
        else $error("stop mode not entered");

    property p_idle_pulse;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == IOP_GEN_DATA_OFS && pwdata[6])
            ##1 !wr_en |-> idle_req ##1 !idle_req;
    endproperty
    a_idle_pulse: assert property (p_idle_pulse) // RL8
        else $error("idle request not a single pulse");

    property p_alt_phase;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == IOP_GEN_CFG_OFS)
            |=> ##1 serial_alt_phase == $past(pwdata[6], 2);
    endproperty
    a_alt_phase: assert property (p_alt_phase) // RL9
        else $error("serial phase not following config bit 6");

    property p_restart_delay;
        @(posedge pclk) disable iff (!presetn)
        (!osc_rc_option && $past(!osc_rc_option)) |-> !restart_delay_en;
    endproperty
    a_restart_delay: assert property (p_restart_delay) // RL10
        else $error("restart delay set without RC option");

    property p_stop_exit;
        @(posedge pclk) disable iff (!presetn)
        (stop_mode && restart_rise && !wr_en) |=> !stop_mode;
    endproperty
    a_stop_exit: assert property (p_stop_exit) // RL11
        else $error("stop mode not left on restart edge");

    property p_xtal_drive;
        @(posedge pclk) disable iff (!presetn)
        (presetn && !osc_rc_option) |=> !gen_pin_oe_n[7] && !gen_pin_pu[7];
    endproperty
    a_xtal_drive: assert property (p_xtal_drive) // RL12
        else $error("oscillator bit not driven in crystal mode");

    property p_pin_read;
        @(posedge pclk) disable iff (!presetn)
        (acc && !pready && !pwrite && paddr == IOP_GEN_PIN_OFS)
            |=> prdata[7:0] == $past(gen_s_reg);
    endproperty
    a_pin_read: assert property (p_pin_read) // RL18
        else $error("pin read not the sampled level");

    property p_sel_route;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_sel_reg && gen_cfg_reg[5]) |=> gen_pin_out[5]
            == $past(serial_clock_src);
    endproperty
    a_sel_route: assert property (p_sel_route) // RL17
        else $error("serial clock not routed to bit 5");

endmodule

`default_nettype wire

// File: test/iop_board.sv
`timescale 1ns/1ps
`default_nettype none

module iop_board #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic [W-1:0] drv_val,
    input  wire logic [W-1:0] drv_oe_n,
    input  wire logic [W-1:0] drv_pu,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output var  logic [W-1:0] level
);
    logic [W-1:0] last_q = '0;

    // Chip drive wins, then the board driver, then the pull-up.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!drv_oe_n[i])
                level[i] = drv_val[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else if (drv_pu[i])
                level[i] = 1'b1;
            else
                level[i] = ~last_q[i]; // A floating pin keeps changing.
        end
    end

    // Remembers the last level for the floating case.
    always @(posedge pclk) begin
        last_q <= level;
    end
endmodule
`default_nettype wire

// File: test/iop_port_set_bench.sv
`timescale 1ns/1ps
`default_nettype none

module iop_port_set_bench;
    import iop_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr;
    logic [3:0]  wk_in, wk_out, wk_oe_n, wk_pu, mi_wake, out_port;
    logic [3:0]  wk_en = 4'hf, wk_val = 4'h0;
    logic [7:0]  gn_in, gn_out, gn_oe_n, gn_pu, ana_lvl, c, d, nc;
    logic [7:0]  gn_en = 8'hff, gn_val = 8'h00, ana_in = 8'h00;
    logic        rc_opt = 1'b1, osc_in = 1'b0, fault = 1'b0;
    logic        sck = 1'b0, sdo = 1'b0;
    logic        sdi, alt_ph, t_io, t_cap, eirq, stop_m, idle_r, rdly, irq;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int          num_errors = 0, total_checks = 0, cycles = 0;
    int          idle_cnt = 0, wake_cnt = 0, seed = 32'h7dbf;

    iop_port_set dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_pin_in(wk_in), .wake_pin_out(wk_out), .wake_pin_oe_n(wk_oe_n),
        .wake_pin_pu(wk_pu), .gen_pin_in(gn_in), .gen_pin_out(gn_out),
        .gen_pin_oe_n(gn_oe_n), .gen_pin_pu(gn_pu), .analog_pin_in(ana_in),
        .analog_level(ana_lvl), .out_port(out_port), .osc_rc_option(rc_opt),
        .osc_clock_in(osc_in), .fault_monitor_in(fault),
        .serial_clock_src(sck), .serial_data_src(sdo),
        .serial_data_in(sdi), .serial_alt_phase(alt_ph),
        .timer_io_pin(t_io), .timer_capture_pin(t_cap), .ext_irq_in(eirq),
        .multi_input_wakeup(mi_wake), .stop_mode(stop_m),
        .idle_req(idle_r), .restart_delay_en(rdly), .irq(irq));
    iop_board #(.W(4)) wk_u (.pclk(pclk), .drv_val(wk_out),
        .drv_oe_n(wk_oe_n), .drv_pu(wk_pu), .ext_en(wk_en),
        .ext_val(wk_val), .level(wk_in));
    iop_board #(.W(8)) gn_u (.pclk(pclk), .drv_val(gn_out),
        .drv_oe_n(gn_oe_n), .drv_pu(gn_pu), .ext_en(gn_en),
        .ext_val(gn_val), .level(gn_in));

    // Free-running bench clock.
    always #5 pclk = ~pclk;

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One bus transfer; the expected answer is noted before it starts.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic [32:0] want);
        exp_q.push_back(want);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        apb(1'b1, a, v, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {1'b0, v});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Matches finished transfers to notes, counts pulses, cuts hangs.
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            test_done();
        end else begin
            if (psel && penable && pready === 1'b1) begin
                e = exp_q.pop_front();
                check({pslverr, prdata}, e);
            end
            if (idle_r === 1'b1)
                idle_cnt++;
            wake_cnt += $countones(mi_wake);
        end
    end

    // Main sequence of tests.
    initial begin
        tick(5);
        check(out_port, 4'hf);
        check({wk_oe_n, gn_oe_n}, 12'hfff);
        presetn <= 1'b1;
        rd(IOP_WAKE_CFG_OFS, 0);
        rd(IOP_GEN_DATA_OFS, 0);
        apb(1'b0, 8'h2c, 0, {1'b1, 32'h0});
        apb(1'b1, 8'h30, 32'hffff_ffff, {1'b1, 32'h0});
        $display("reset and map test done");
        wr(IOP_MASK_OFS, 0);
        wr(IOP_GEN_DATA_OFS, 8'h80);
        tick(2);
        check(stop_m, 1);
        wk_val <= 4'hf;
        gn_val <= 8'h81;
        tick(4);
        check(stop_m, 0);
        check(wake_cnt, 4);
        check(irq, 0);
        wr(IOP_MASK_OFS, 8'h3f);
        tick(2);
        check(irq, 1);
        rd(IOP_STATUS_OFS, 8'h3f);
        tick(2);
        check(irq, 0);
        rd(IOP_STATUS_OFS, 0);
        wr(IOP_GEN_DATA_OFS, 8'h40);
        tick(3);
        check(idle_cnt, 1);
        $display("event test done");
        for (int i = 0; i < 6; i++) begin
            c = $random(seed);
            d = $random(seed);
            nc = ~c;
            wr(IOP_WAKE_CFG_OFS, c);
            wr(IOP_WAKE_DATA_OFS, d);
            wr(IOP_GEN_CFG_OFS, c & 8'h3f);
            wr(IOP_GEN_DATA_OFS, d & 8'h3f);
            tick(3);
            check(wk_oe_n, nc[7:4]);
            check(wk_out & c[7:4], c[7:4] & d[7:4]);
            check(wk_pu, nc[7:4] & d[7:4]);
            check(gn_oe_n & 8'h3d, nc & 8'h3d);
            check(gn_out & c & 8'h3d, c & d & 8'h3d);
            check(gn_pu & 8'h3d, nc & d & 8'h3d);
            rd(IOP_WAKE_DATA_OFS, d);
            rd(IOP_GEN_DATA_OFS, d & 8'h3f);
        end
        $display("decode test done");
        d = $random(seed);
        wr(IOP_GEN_CFG_OFS, 8'hf0);
        wr(IOP_CTRL_OFS, 1);
        sck <= d[0];
        sdo <= d[1];
        tick(3);
        check({alt_ph, rdly}, 2'b11);
        check(gn_out[5:4], {d[0], d[1]});
        wr(IOP_CTRL_OFS, 0);
        wr(IOP_GEN_DATA_OFS, 8'h20);
        tick(3);
        check(gn_out[5:4], 2'b10);
        fault <= 1'b1;
        tick(3);
        check({gn_oe_n[1], gn_out[1]}, 2'b00);
        fault <= 1'b0;
        $display("serial and fault test done");
        wr(IOP_WAKE_CFG_OFS, 0);
        wr(IOP_GEN_CFG_OFS, 0);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            nc = ~d;
            wk_val <= d[3:0];
            gn_val <= d;
            ana_in <= nc;
            wr(IOP_WAKE_DATA_OFS, nc);
            wr(IOP_OUT_DATA_OFS, d[7:4]);
            tick(3);
            rd(IOP_WAKE_PIN_OFS, {d[3:0], 4'hf});
            rd(IOP_GEN_PIN_OFS, d);
            rd(IOP_ANA_PIN_OFS, nc);
            check(ana_lvl, nc);
            check(out_port, d[7:4]);
            check({sdi, t_io, t_cap, eirq}, {d[6], d[3], d[2], d[0]});
        end
        $display("pin read test done");
        presetn <= 1'b0;
        rc_opt <= 1'b0;
        tick(2);
        check(out_port, 4'hf);
        presetn <= 1'b1;
        wr(IOP_GEN_CFG_OFS, 8'h80);
        osc_in <= 1'b1;
        tick(3);
        check({gn_oe_n[7], gn_out[7], rdly}, 3'b010);
        osc_in <= 1'b0;
        tick(3);
        check({gn_oe_n[7], gn_out[7]}, 2'b00);
        $display("crystal test done");
        test_done();
    end
endmodule
`default_nettype wire
